// *** design/cvr_top.sv ***
// Register file for the extra sample capacitor code and the two result byte pairs.
// Assumes a same-clock conversion sequencer that pulses CONV_DONE_IN with the result.
`timescale 1ns/1ps
module cvr_top
    import cvr_pkg::*;
#(
    parameter int ADDR_W = 8
)(
    // Clock and reset
    input  wire logic              REF_CLK_IN,
    input  wire logic              RST_IN,
    // AXI4-Lite write address
    input  wire logic              AWVALID_IN,
    input  wire logic [ADDR_W-1:0] AWADDR_IN,
    output logic                   AWREADY_OUT,
    // AXI4-Lite write data
    input  wire logic              WVALID_IN,
    input  wire logic [31:0]       WDATA_IN,
    input  wire logic [3:0]        WSTRB_IN,
    output logic                   WREADY_OUT,
    // AXI4-Lite write response
    output logic                   BVALID_OUT,
    output logic [1:0]             BRESP_OUT,
    input  wire logic              BREADY_IN,
    // AXI4-Lite read address
    input  wire logic              ARVALID_IN,
    input  wire logic [ADDR_W-1:0] ARADDR_IN,
    output logic                   ARREADY_OUT,
    // AXI4-Lite read data
    output logic                   RVALID_OUT,
    output logic [31:0]            RDATA_OUT,
    output logic [1:0]             RRESP_OUT,
    input  wire logic              RREADY_IN,
    // Conversion sequencer
    input  wire logic              CONV_DONE_IN,
    input  wire logic [9:0]        CONV_RESULT_IN,
    input  wire logic              SEQ_ACTIVE_IN,
    input  wire logic              SEQ_SECOND_IN,
    // Analog front end
    output logic [2:0]             EXTRA_CAP_CODE_OUT,
    output logic [6:0]             CAP_UNITS_OUT,
    output logic                   RESULT_FORMAT_OUT
);
    // Offsets reach 0x18, so five address bits are the least that works
    if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr_w
        $error("cvr_top: ADDR_W must lie between 5 and 32");
    end

    // Address decode: one-hot register select, zero when unmapped
    function automatic logic [CVR_NUM_REGS-1:0] reg_sel(input logic [ADDR_W-1:0] addr);
        logic [CVR_NUM_REGS-1:0] sel;
        logic [7:0]              low;
        sel = '0;
        low = 8'(addr);
        if (ADDR_W == 8 || (addr >> 8) == '0) begin
            case (low)
                CVR_OFS_CAP:     sel[0] = 1'b1;
                CVR_OFS_CTRL:    sel[1] = 1'b1;
                CVR_OFS_STAT:    sel[2] = 1'b1;
                CVR_OFS_RES0_HI: sel[3] = 1'b1;
                CVR_OFS_RES0_LO: sel[4] = 1'b1;
                CVR_OFS_RES1_HI: sel[5] = 1'b1;
                CVR_OFS_RES1_LO: sel[6] = 1'b1;
                default:         sel = '0;
            endcase
        end
        return sel;
    endfunction : reg_sel

    // Bus state
    logic              awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic              aw_got_q, w_got_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0]       wdata_q;
    logic              wstrb0_q;
    logic [1:0]        bresp_q, rresp_q;
    logic [31:0]       rdata_q;

    // Block state
    logic [CVR_CAP_W-1:0]     cap_q;
    logic [CVR_CAP_UNITS-1:0] units_q;
    logic                     fmt_q;
    logic                     pair_q;
    cvr_byte_t                res_hi_q [2];
    cvr_byte_t                res_lo_q [2];

    // Write channel decode
    wire                      aw_hs    = AWVALID_IN & awready_q;
    wire                      w_hs     = WVALID_IN & wready_q;
    wire                      have_aw  = aw_got_q | aw_hs;
    wire                      have_w   = w_got_q | w_hs;
    wire                      do_write = have_aw & have_w;
    wire [ADDR_W-1:0]         wr_addr  = aw_hs ? AWADDR_IN : awaddr_q;
    wire [31:0]               wr_data  = w_hs ? WDATA_IN : wdata_q;
    wire                      wr_lane0 = w_hs ? WSTRB_IN[0] : wstrb0_q;
    wire [CVR_NUM_REGS-1:0]   wr_sel   = reg_sel(wr_addr);
    wire [CVR_NUM_REGS-1:0]   wr_en    = (do_write & wr_lane0) ? wr_sel : '0;
    wire cvr_byte_t           wr_byte  = wr_data[CVR_BYTE_W-1:0];
    wire                      aw_got_d = have_aw & ~do_write;
    wire                      w_got_d  = have_w & ~do_write;
    wire                      bvalid_d = do_write | (bvalid_q & ~BREADY_IN);

    // Read channel decode
    wire                      ar_hs    = ARVALID_IN & arready_q;
    wire [CVR_NUM_REGS-1:0]   rd_sel   = reg_sel(ARADDR_IN);
    wire                      rvalid_d = ar_hs | (rvalid_q & ~RREADY_IN);
    wire [31:0]               stat_word = 32'(pair_q) << CVR_PAIR_BIT;
    wire [31:0]               ctrl_word = 32'(fmt_q) << CVR_FMT_BIT;
    wire [31:0]               rd_word =
        ({32{rd_sel[0]}} & 32'(cap_q))       |
        ({32{rd_sel[1]}} & ctrl_word)        |
        ({32{rd_sel[2]}} & stat_word)        |
        ({32{rd_sel[3]}} & 32'(res_hi_q[0])) |
        ({32{rd_sel[4]}} & 32'(res_lo_q[0])) |
        ({32{rd_sel[5]}} & 32'(res_hi_q[1])) |
        ({32{rd_sel[6]}} & 32'(res_lo_q[1]));

    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            aw_got_q  <= 1'b0;
            w_got_q   <= 1'b0;
        end else begin
            awready_q <= ~aw_got_d & ~bvalid_d;
            wready_q  <= ~w_got_d & ~bvalid_d;
            bvalid_q  <= bvalid_d;
            arready_q <= ~rvalid_d;
            rvalid_q  <= rvalid_d;
            aw_got_q  <= aw_got_d;
            w_got_q   <= w_got_d;
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (aw_hs) begin
            awaddr_q <= AWADDR_IN;
        end
        if (w_hs) begin
            wdata_q  <= WDATA_IN;
            wstrb0_q <= WSTRB_IN[0];
        end
        if (do_write) begin
            bresp_q <= (|wr_sel) ? CVR_RESP_OKAY : CVR_RESP_SLVERR;
        end
        if (ar_hs) begin
            rdata_q <= rd_word;
            rresp_q <= (|rd_sel) ? CVR_RESP_OKAY : CVR_RESP_SLVERR;
        end
    end

    // Capacitor code and unit enables
    wire [CVR_CAP_W-1:0]     cap_d = wr_en[0] ? wr_byte[CVR_CAP_W-1:0] : cap_q;
    wire [CVR_CAP_UNITS-1:0] units_d;
    genvar gi;
    generate
        for (gi = 0; gi < CVR_CAP_UNITS; gi++) begin : g_unit
            // one 4 pF unit per code step
            assign units_d[gi] = (cap_d > CVR_CAP_W'(gi));
        end
    endgenerate

    always_ff @(posedge REF_CLK_IN) begin
        // capacitor code cleared by every reset
        if (RST_IN) begin
            cap_q   <= CVR_CAP_RST;
            units_q <= '0;
            fmt_q   <= CVR_FMT_RST;
            pair_q  <= 1'b0;
        end else begin
            cap_q   <= cap_d;
            // code zero leaves every unit off
            units_q <= units_d;
            fmt_q   <= wr_en[1] ? wr_byte[CVR_FMT_BIT] : fmt_q;
            pair_q  <= SEQ_ACTIVE_IN & SEQ_SECOND_IN;
        end
    end

    // Result placement
    cvr_byte_t jus_hi;
    cvr_byte_t jus_lo;
    cvr_justify cvr_justify_inst (
        .result_in (CONV_RESULT_IN),
        .right_in  (fmt_q),
        .high_out  (jus_hi),
        .low_out   (jus_lo)
    );

    // result bytes have no reset term
    always_ff @(posedge REF_CLK_IN) begin
        for (int p = 0; p < 2; p++) begin
            // finished conversion overrides a same-cycle write
            if (CONV_DONE_IN && SEQ_SECOND_IN == p[0]) begin
                res_hi_q[p] <= jus_hi;
                res_lo_q[p] <= jus_lo;
            end else begin
                if (wr_en[3 + 2 * p]) begin
                    res_hi_q[p] <= wr_byte;
                end
                if (wr_en[4 + 2 * p]) begin
                    res_lo_q[p] <= wr_byte;
                end
            end
        end
    end

    assign AWREADY_OUT        = awready_q;
    assign WREADY_OUT         = wready_q;
    assign BVALID_OUT         = bvalid_q;
    assign BRESP_OUT          = bresp_q;
    assign ARREADY_OUT        = arready_q;
    assign RVALID_OUT         = rvalid_q;
    assign RDATA_OUT          = rdata_q;
    assign RRESP_OUT          = rresp_q;
    assign EXTRA_CAP_CODE_OUT = cap_q;
    assign CAP_UNITS_OUT      = units_q;
    assign RESULT_FORMAT_OUT  = fmt_q;

    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (RST_IN);

    a_cap_read_upper: assert property (ar_hs && rd_sel[0] |=> RDATA_OUT[31:3] == '0)
        else $error("capacitor read shows upper bits");
    a_cap_write_code: assert property (wr_en[0] |=> EXTRA_CAP_CODE_OUT == $past(wr_byte[2:0]))
        else $error("capacitor code not taken from write");
    a_cap_unit_count: assert property ($countones(CAP_UNITS_OUT) == 32'(EXTRA_CAP_CODE_OUT))
        else $error("unit count differs from code");
    a_cap_zero_none: assert property (wr_en[0] && wr_byte[2:0] == '0 |=> CAP_UNITS_OUT == '0)
        else $error("units enabled for code zero");
    a_left_high_low: assert property (CONV_DONE_IN && !fmt_q |=>
        res_hi_q[$past(SEQ_SECOND_IN)] == $past(CONV_RESULT_IN[9:2]) &&
        res_lo_q[$past(SEQ_SECOND_IN)][7:6] == $past(CONV_RESULT_IN[1:0]))
        else $error("left placement wrong");
    a_left_low_rsv: assert property (CONV_DONE_IN && !fmt_q |=> res_lo_q[$past(SEQ_SECOND_IN)][5:0] == '0)
        else $error("left low reserved bits set");
    a_right_high: assert property (CONV_DONE_IN && fmt_q |=>
        res_hi_q[$past(SEQ_SECOND_IN)] == {6'h00, $past(CONV_RESULT_IN[9:8])})
        else $error("right high placement wrong");
    a_right_low: assert property (CONV_DONE_IN && fmt_q |=>
        res_lo_q[$past(SEQ_SECOND_IN)] == $past(CONV_RESULT_IN[7:0]))
        else $error("right low placement wrong");
    a_reset_cap_zero: assert property (disable iff (1'b0) RST_IN |=> EXTRA_CAP_CODE_OUT == CVR_CAP_RST)
        else $error("capacitor code survives reset");
    a_reset_keeps_res: assert property (disable iff (1'b0)
        RST_IN && !CONV_DONE_IN |=> $stable(res_hi_q[0]) && $stable(res_lo_q[1]))
        else $error("result bytes disturbed by reset");
    a_pair_flag: assert property (##1 pair_q == $past(SEQ_ACTIVE_IN && SEQ_SECOND_IN))
        else $error("pair flag wrong");
    a_pair_other_kept: assert property (CONV_DONE_IN && !SEQ_SECOND_IN && !wr_en[5] |=> $stable(res_hi_q[1]))
        else $error("conversion hit the wrong pair");

    // Bus handshake checks
    a_bresp_held: assert property (BVALID_OUT && !BREADY_IN |=> BVALID_OUT && $stable(BRESP_OUT))
        else $error("write response dropped before taken");
    a_bvalid_ends: assert property (BVALID_OUT && BREADY_IN |=> !BVALID_OUT)
        else $error("write response repeated");
    a_rdata_held: assert property (RVALID_OUT && !RREADY_IN |=>
        RVALID_OUT && $stable(RDATA_OUT) && $stable(RRESP_OUT))
        else $error("read data dropped before taken");
    a_write_answer: assert property (do_write |=> BVALID_OUT)
        else $error("write not answered");
    a_read_answer: assert property (ar_hs |=> RVALID_OUT)
        else $error("read not answered");
    a_write_refused: assert property (BVALID_OUT |-> !AWREADY_OUT && !WREADY_OUT)
        else $error("write accepted during response");
    a_read_refused: assert property (RVALID_OUT |-> !ARREADY_OUT)
        else $error("read accepted during response");
    a_unmapped_error: assert property (ar_hs && rd_sel == '0 |=> RRESP_OUT == CVR_RESP_SLVERR && RDATA_OUT == '0)
        else $error("unmapped read not refused");
    // Register field checks
    a_lane_off_kept: assert property (do_write && !wr_lane0 |=>
        $stable(EXTRA_CAP_CODE_OUT) && $stable(RESULT_FORMAT_OUT))
        else $error("write with lane zero off changed a field");
    a_format_write: assert property (wr_en[1] |=> RESULT_FORMAT_OUT == $past(wr_byte[CVR_FMT_BIT]))
        else $error("format flag not taken from write");
    a_pair_flag_idle: assert property (!SEQ_ACTIVE_IN |=> !pair_q)
        else $error("pair flag set while idle");

    c_conv_first: cover property (CONV_DONE_IN && !SEQ_SECOND_IN && !fmt_q);
    c_conv_second: cover property (CONV_DONE_IN && SEQ_SECOND_IN && fmt_q);
    c_write_then_read: cover property (wr_en[0] ##[1:10] ar_hs && rd_sel[0]);
    c_unmapped: cover property (ar_hs && rd_sel == '0);
    c_lane_off: cover property (do_write && !wr_lane0);
endmodule : cvr_top

// *** design/cvr_pkg.sv ***
// Shared constants for the sample-capacitor select and result placement block.
// Assumes a 32-bit AXI4-Lite register port with byte addresses.
package cvr_pkg;
    // Register byte offsets
    localparam logic [7:0] CVR_OFS_CAP     = 8'h00;
    localparam logic [7:0] CVR_OFS_CTRL    = 8'h04;
    localparam logic [7:0] CVR_OFS_STAT    = 8'h08;
    localparam logic [7:0] CVR_OFS_RES0_HI = 8'h0C;
    localparam logic [7:0] CVR_OFS_RES0_LO = 8'h10;
    localparam logic [7:0] CVR_OFS_RES1_HI = 8'h14;
    localparam logic [7:0] CVR_OFS_RES1_LO = 8'h18;
    localparam int         CVR_NUM_REGS    = 7;

    // Field layout
    localparam int         CVR_CAP_W       = 3;
    localparam int         CVR_CAP_UNITS   = 7;
    localparam int         CVR_CAP_STEP_PF = 4;
    localparam int         CVR_FMT_BIT     = 7;
    localparam int         CVR_PAIR_BIT    = 2;
    localparam int         CVR_RES_W       = 10;
    localparam int         CVR_BYTE_W      = 8;
    localparam int         CVR_RSV_W       = 6;

    // Reset values
    localparam logic [2:0] CVR_CAP_RST     = 3'h0;
    localparam logic       CVR_FMT_RST     = 1'b0;

    // Bus answers
    localparam logic [1:0] CVR_RESP_OKAY   = 2'h0;
    localparam logic [1:0] CVR_RESP_SLVERR = 2'h2;

    typedef logic [CVR_BYTE_W-1:0] cvr_byte_t;
endpackage : cvr_pkg

// *** design/cvr_justify.sv ***
// Places a ten-bit conversion result into a high/low byte pair.
// Purely combinational; the caller registers the outputs.
`timescale 1ns/1ps
module cvr_justify
    import cvr_pkg::*;
(
    // Result in
    input  wire logic [CVR_RES_W-1:0] result_in,
    input  wire logic                 right_in,
    // Byte pair out
    output cvr_byte_t                 high_out,
    output cvr_byte_t                 low_out
);
    wire cvr_byte_t high_left;
    wire cvr_byte_t low_left;
    wire cvr_byte_t high_right;
    wire cvr_byte_t low_right;

    assign high_left  = result_in[CVR_RES_W-1:CVR_RES_W-CVR_BYTE_W];
    // bits 1..0 on top of low byte
    assign low_left   = {result_in[CVR_RES_W-CVR_BYTE_W-1:0], {CVR_RSV_W{1'b0}}};
    // bits 9..8 at bottom of high byte
    assign high_right = {{CVR_RSV_W{1'b0}}, result_in[CVR_RES_W-1:CVR_BYTE_W]};
    assign low_right  = result_in[CVR_BYTE_W-1:0];

    assign high_out = right_in ? high_right : high_left;
    assign low_out  = right_in ? low_right  : low_left;
endmodule : cvr_justify

// *** bench/cvr_top_test.sv ***
// Self-checking bench for cvr_top: AXI4-Lite register tasks and conversion scenarios.
// Assumes the register map of cvr_pkg and a sequencer on the same clock as the bus.
`timescale 1ns/1ps
module cvr_top_test import cvr_pkg::*;;
    logic        ref_clk     = 1'b0;
    logic        rst         = 1'b1;
    logic        awvalid     = 1'b0;
    logic [7:0]  awaddr      = 8'h00;
    logic        wvalid      = 1'b0;
    logic [31:0] wdata       = 32'h0;
    logic [3:0]  wstrb       = 4'h0;
    logic [3:0]  wr_strb     = 4'hF;
    logic        bready      = 1'b0;
    logic        arvalid     = 1'b0;
    logic [7:0]  araddr      = 8'h00;
    logic        rready      = 1'b0;
    logic        conv_done   = 1'b0;
    logic [9:0]  conv_result = 10'h000;
    logic        seq_active  = 1'b0;
    logic        seq_second  = 1'b0;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [2:0]  cap_code;
    logic [6:0]  cap_units;
    logic        fmt;
    int          miscompares = 0;
    int          comparisons = 0;

    cvr_top cvr_top_inst (
        .REF_CLK_IN(ref_clk), .RST_IN(rst),
        .AWVALID_IN(awvalid), .AWADDR_IN(awaddr), .AWREADY_OUT(awready),
        .WVALID_IN(wvalid), .WDATA_IN(wdata), .WSTRB_IN(wstrb), .WREADY_OUT(wready),
        .BVALID_OUT(bvalid), .BRESP_OUT(bresp), .BREADY_IN(bready),
        .ARVALID_IN(arvalid), .ARADDR_IN(araddr), .ARREADY_OUT(arready),
        .RVALID_OUT(rvalid), .RDATA_OUT(rdata), .RRESP_OUT(rresp), .RREADY_IN(rready),
        .CONV_DONE_IN(conv_done), .CONV_RESULT_IN(conv_result),
        .SEQ_ACTIVE_IN(seq_active), .SEQ_SECOND_IN(seq_second),
        .EXTRA_CAP_CODE_OUT(cap_code), .CAP_UNITS_OUT(cap_units), .RESULT_FORMAT_OUT(fmt)
    );

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic end_of_test();
        if (miscompares == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (5000) @(posedge ref_clk);
        miscompares++;
        end_of_test();
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Address and data offered together; each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_p;
        logic w_p;
        @(posedge ref_clk);
        aw_p = 1'b1;
        w_p = 1'b1;
        awaddr <= a;
        wdata <= d;
        wstrb <= wr_strb;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (aw_p && awready === 1'b1) begin
                aw_p = 1'b0;
                awvalid <= 1'b0;
            end
            if (w_p && wready === 1'b1) begin
                w_p = 1'b0;
                wvalid <= 1'b0;
            end
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_p;
        @(posedge ref_clk);
        ar_p = 1'b1;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (ar_p && arready === 1'b1) begin
                ar_p = 1'b0;
                arvalid <= 1'b0;
            end
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd

    task automatic wrq(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
        chk({30'h0, r}, {30'h0, CVR_RESP_OKAY});
    endtask : wrq

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk(d, exp);
    endtask : rdchk

    task automatic rst_pulse();
        rst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
    endtask : rst_pulse

    // Two back-to-back conversions: first into pair 0, then into pair 1
    task automatic conv2(input logic [9:0] a, input logic [9:0] b);
        @(posedge ref_clk);
        conv_done <= 1'b1;
        conv_result <= a;
        seq_second <= 1'b0;
        @(posedge ref_clk);
        conv_result <= b;
        seq_second <= 1'b1;
        @(posedge ref_clk);
        conv_done <= 1'b0;
        seq_second <= 1'b0;
    endtask : conv2

    initial begin
        logic [31:0] d;
        logic [1:0]  resp;
        logic [9:0]  a;
        logic [9:0]  b;
        a = 10'h2B5;
        b = 10'h14A;
        rst_pulse();
        rdchk(CVR_OFS_CAP, 32'h0);
        rdchk(CVR_OFS_CTRL, 32'h0);
        chk({25'h0, cap_units}, 32'h0);
        for (int n = 0; n < 8; n++) begin
            wrq(CVR_OFS_CAP, 32'hF8 | 32'(n));
            rdchk(CVR_OFS_CAP, 32'(n));
            chk({29'h0, cap_code}, 32'(n));
            chk({25'h0, cap_units}, 32'((1 << n) - 1));
        end
        // A write with byte lane 0 off changes nothing
        wr_strb = 4'hE;
        wrq(CVR_OFS_CAP, 32'h0);
        wr_strb = 4'hF;
        rdchk(CVR_OFS_CAP, 32'h7);
        chk({29'h0, cap_code}, 32'h7);
        conv2(a, b);
        rdchk(CVR_OFS_RES0_HI, {24'h0, a[9:2]});
        rdchk(CVR_OFS_RES0_LO, {24'h0, a[1:0], 6'h00});
        rdchk(CVR_OFS_RES1_HI, {24'h0, b[9:2]});
        rdchk(CVR_OFS_RES1_LO, {24'h0, b[1:0], 6'h00});
        wrq(CVR_OFS_CTRL, 32'h80);
        chk({31'h0, fmt}, 32'h1);
        rdchk(CVR_OFS_CTRL, 32'h80);
        conv2(b, a);
        rdchk(CVR_OFS_RES0_HI, {30'h0, b[9:8]});
        rdchk(CVR_OFS_RES0_LO, {24'h0, b[7:0]});
        rdchk(CVR_OFS_RES1_HI, {30'h0, a[9:8]});
        rdchk(CVR_OFS_RES1_LO, {24'h0, a[7:0]});
        for (int n = 0; n < 4; n++) begin
            @(posedge ref_clk);
            seq_active <= n[1];
            seq_second <= n[0];
            rdchk(CVR_OFS_STAT, (n == 3) ? 32'h4 : 32'h0);
        end
        @(posedge ref_clk);
        seq_active <= 1'b0;
        seq_second <= 1'b0;
        wrq(CVR_OFS_STAT, 32'hFF);
        rdchk(CVR_OFS_STAT, 32'h0);
        wrq(CVR_OFS_RES1_LO, 32'hA5);
        rdchk(CVR_OFS_RES1_LO, 32'hA5);
        // Unmapped offsets answer with an error
        rd(8'h1C, d, resp);
        chk({30'h0, resp}, {30'h0, CVR_RESP_SLVERR});
        chk(d, 32'h0);
        wr(8'h20, 32'h0, resp);
        chk({30'h0, resp}, {30'h0, CVR_RESP_SLVERR});
        // Reset in mid-run clears the code but keeps the results
        rst_pulse();
        rdchk(CVR_OFS_CAP, 32'h0);
        chk({29'h0, cap_code}, 32'h0);
        rdchk(CVR_OFS_CTRL, 32'h0);
        rdchk(CVR_OFS_RES0_HI, {30'h0, b[9:8]});
        rdchk(CVR_OFS_RES1_LO, 32'hA5);
        end_of_test();
    end
endmodule : cvr_top_test
